// ===== design/ihh_host.sv
`timescale 1ns/10ps
`default_nettype none

module ihh_host (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic link_clk,
    // user command port, mclk domain
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire ihh_pkg::ihh_kind_e cmd_kind,
    input wire logic [2:0] cmd_mode,
    input wire logic cmd_byte,
    input wire logic cmd_cs1,
    input wire logic [2:0] cmd_addr,
    input wire logic [15:0] cmd_wdata,
    input wire logic [7:0] cmd_len,
    input wire logic dma_pause,
    output logic rsp_valid,
    output logic [15:0] rsp_data,
    output logic rsp_wide,
    output logic rsp_last,
    output logic irq,
    // device pins, link domain but interrupt_out, which is synced into mclk
    output logic host_read_strobe_n,
    output logic host_write_strobe_n,
    output logic register_space_select_n,
    output logic card_enable_low_byte_n,
    output logic card_enable_high_byte_n,
    output logic [2:0] host_address_low,
    output logic [15:0] host_data_out,
    output logic host_data_oe_n,
    input wire logic [15:0] host_data_in,
    input wire logic io_ready,
    input wire logic dma_request,
    input wire logic wide_xfer_n,
    input wire logic interrupt_out
);
    import ihh_pkg::*;

    typedef enum logic [3:0] {
        L_IDLE, L_DREQ, L_SETUP, L_ACTIVE, L_WAIT, L_RECOV, L_RESP,
        L_UD_RUN, L_UD_ACK, L_UD_STOP
    } ihh_lstate_e;

    typedef struct packed {
        logic busy;
        logic idle;
        logic req_tog;
        logic ack_tog;
        ihh_kind_e kind;
        logic [2:0] mode;
        logic byte_x;
        logic cs1;
        logic [2:0] addr;
        logic [15:0] wdata;
        logic [7:0] len;
        logic rsp_valid;
        logic [15:0] rsp_data;
        logic rsp_wide;
        logic rsp_last;
        logic irq;
    } ihh_user_s;

    typedef struct packed {
        ihh_lstate_e st;
        logic req_seen;
        logic rsp_tog;
        ihh_kind_e kind;
        logic [2:0] mode;
        logic byte_x;
        logic [7:0] cnt;
        logic [7:0] tot;
        logic [7:0] left;
        logic [15:0] rdata;
        logic wide;
        logic last;
        logic strobe_prev;
        logic rd_n;
        logic wr_n;
        logic dmack_n;
        logic ce0_n;
        logic ce1_n;
        logic [2:0] addr;
        logic [15:0] dout;
        logic doe_n;
    } ihh_link_s;

    ihh_user_s u;
    ihh_user_s next_u;
    ihh_link_s l;
    ihh_link_s next_l;

    logic [15:0] data_s;
    logic iordy_s;
    logic dreq_s;
    logic wide_n_s;
    logic req_s;
    logic ack_s;
    logic pause_s;
    logic link_rst_n;
    logic rsp_tog_s;
    logic irq_s;

    // device input pins but interrupt_out, plus the mclk toggles, pause and reset, pass two link flops; command fields are read directly
    ihh_sync #(.W(23)) u_link_sync (
        .clk(link_clk),
        .d({host_data_in, io_ready, dma_request, wide_xfer_n, u.req_tog,
            u.ack_tog, dma_pause, resetn}),
        .q({data_s, iordy_s, dreq_s, wide_n_s, req_s, ack_s, pause_s,
            link_rst_n})
    );

    // response toggle and interrupt line into the mclk domain
    ihh_sync #(.W(2)) u_user_sync (
        .clk(mclk),
        .d({l.rsp_tog, interrupt_out}),
        .q({rsp_tog_s, irq_s})
    );

    // user side: take a command, answer each word the link hands over
    always_comb begin
        next_u = u;
        next_u.rsp_valid = 1'b0;
        next_u.irq = irq_s;
        if (cmd_valid && !u.busy) begin
            next_u.busy = 1'b1;
            next_u.req_tog = ~u.req_tog;
            next_u.kind = cmd_kind;
            next_u.mode = cmd_mode;
            next_u.byte_x = cmd_byte;
            next_u.cs1 = cmd_cs1;
            next_u.addr = cmd_addr;
            next_u.wdata = cmd_byte ? (cmd_wdata & BYTE_MASK) : cmd_wdata;
            next_u.len = (cmd_len == 8'h00) ? ONE8 : cmd_len;
        end
        // link words are held until acked, so reading them here is safe
        if (rsp_tog_s != u.ack_tog) begin
            next_u.ack_tog = rsp_tog_s;
            next_u.rsp_valid = 1'b1;
            next_u.rsp_data = l.rdata;
            next_u.rsp_wide = l.wide;
            next_u.rsp_last = l.last;
            if (l.last) begin
                next_u.busy = 1'b0;
            end
        end
        // ready kept in its own flop so the port needs no gate
        next_u.idle = !next_u.busy;
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            u <= '0;
            u.idle <= 1'b1;
        end else begin
            u <= next_u;
        end
    end

    // link side: drive the pins with mode timing counted in link cycles
    always_comb begin
        logic [2:0] dm;
        logic [7:0] act_min;
        logic [7:0] rec_min;
        logic [7:0] cyc_min;
        logic [7:0] set_min;
        logic is_dma;
        logic is_rd;
        logic wait_ok;
        logic [7:0] hold_min;
        act_min = '0;
        rec_min = '0;
        cyc_min = '0;
        set_min = '0;
        dm = (l.mode > DMA_TOP_MODE) ? DMA_TOP_MODE : l.mode;
        is_dma = (l.kind == IHH_DMA_RD) || (l.kind == IHH_DMA_WR);
        is_rd = (l.kind == IHH_PIO_RD) || (l.kind == IHH_DMA_RD);
        wait_ok = !is_dma && (l.mode <= WAIT_TOP_MODE);
        // strobe stays low until synced data and io_ready can be seen;
        // short modes get a longer strobe, which the host may always do
        hold_min = wait_ok ? ihh_cyc(WAIT_SAMPLE_DELAY_NS) + 8'(SYNC_LAG)
                           : 8'(SYNC_LAG) + ONE8;
        if (is_dma) begin
            act_min = ihh_cyc(DMA_ACTIVE_MIN[dm]);
            rec_min = is_rd ? ihh_cyc(DMA_READ_RECOVERY_MIN[dm])
                            : ihh_cyc(DMA_WRITE_RECOVERY_MIN[dm]);
            cyc_min = ihh_cyc(DMA_T0[dm]);
            set_min = ihh_cyc(DMA_CE_SETUP[dm]);
        end else begin
            act_min = l.byte_x ? ihh_cyc(PIO_T2B[l.mode])
                               : ihh_cyc(PIO_T2[l.mode]);
            rec_min = ihh_cyc(PIO_T2I[l.mode]);
            cyc_min = ihh_cyc(PIO_T0[l.mode]);
            set_min = ihh_cyc(PIO_T1[l.mode]);
        end
        next_l = l;
        next_l.cnt = l.cnt + ONE8;
        next_l.tot = l.tot + ONE8;
        case (l.st)
            L_IDLE: begin
                if (req_s != l.req_seen) begin
                    next_l.req_seen = req_s;
                    next_l.kind = u.kind;
                    next_l.mode = (u.mode >= 3'(PIO_MODES)) ? 3'(PIO_MODES - 1)
                                                          : u.mode;
                    next_l.byte_x = u.byte_x;
                    next_l.left = u.len;
                    next_l.addr = u.addr;
                    next_l.dout = u.wdata;
                    next_l.doe_n = !((u.kind == IHH_PIO_WR) ||
                                     (u.kind == IHH_DMA_WR));
                    next_l.cnt = '0;
                    next_l.tot = '0;
                    if (u.kind == IHH_PIO_RD || u.kind == IHH_PIO_WR) begin
                        next_l.ce0_n = u.cs1;
                        next_l.ce1_n = !u.cs1;
                        next_l.st = L_SETUP;
                    end else begin
                        next_l.dmack_n = 1'b0;
                        next_l.st = L_DREQ;
                    end
                end
            end
            L_DREQ: begin
                // device suspension and host pause both hold us here
                next_l.cnt = '0;
                next_l.tot = '0;
                if (dreq_s && !pause_s) begin
                    if (l.kind == IHH_UDMA_RD) begin
                        next_l.wr_n = 1'b0;
                        next_l.rd_n = 1'b0;
                        next_l.strobe_prev = iordy_s;
                        next_l.st = L_UD_RUN;
                    end else begin
                        next_l.st = L_SETUP;
                    end
                end
            end
            L_SETUP: begin
                if (l.cnt + ONE8 >= set_min) begin
                    next_l.rd_n = !is_rd;
                    next_l.wr_n = is_rd;
                    next_l.cnt = '0;
                    next_l.tot = '0;
                    next_l.st = L_ACTIVE;
                end
            end
            L_ACTIVE: begin
                // io_ready is looked at once, one sample delay plus the sync lag in
                if (wait_ok && !iordy_s && l.cnt == hold_min) begin
                    next_l.st = L_WAIT;
                end else if (l.cnt + ONE8 >= act_min &&
                             l.cnt >= hold_min) begin
                    next_l.rdata = l.byte_x ? (data_s & BYTE_MASK) : data_s;
                    next_l.wide = !wide_n_s && !is_dma &&
                                  (l.mode <= WIDE_TOP_MODE);
                    next_l.rd_n = 1'b1;
                    next_l.wr_n = 1'b1;
                    next_l.cnt = '0;
                    next_l.st = L_RECOV;
                end
            end
            L_WAIT: begin
                // data rides the same sync depth as io_ready, so it is valid
                if (iordy_s) begin
                    next_l.rdata = l.byte_x ? (data_s & BYTE_MASK) : data_s;
                    next_l.wide = !wide_n_s && (l.mode <= WIDE_TOP_MODE);
                    next_l.rd_n = 1'b1;
                    next_l.wr_n = 1'b1;
                    next_l.cnt = '0;
                    next_l.st = L_RECOV;
                end
            end
            L_RECOV: begin
                // stretch recovery until the whole cycle reaches its minimum
                if (l.cnt + ONE8 >= rec_min && l.tot + ONE8 >= cyc_min) begin
                    next_l.doe_n = 1'b1;
                    next_l.dmack_n = 1'b1;
                    next_l.ce0_n = 1'b1;
                    next_l.ce1_n = 1'b1;
                    next_l.last = 1'b1;
                    next_l.rsp_tog = ~l.rsp_tog;
                    next_l.st = L_RESP;
                end
            end
            L_RESP: begin
                if (ack_s == l.rsp_tog) begin
                    next_l.st = L_IDLE;
                end
            end
            L_UD_RUN: begin
                // each edge of the device strobe is one word
                if (iordy_s != l.strobe_prev) begin
                    next_l.strobe_prev = iordy_s;
                    next_l.rdata = data_s;
                    next_l.wide = 1'b1;
                    next_l.last = (l.left == ONE8);
                    next_l.left = l.left - ONE8;
                    next_l.rsp_tog = ~l.rsp_tog;
                    next_l.rd_n = 1'b1;
                    next_l.st = L_UD_ACK;
                end
            end
            L_UD_ACK: begin
                if (ack_s == l.rsp_tog) begin
                    next_l.cnt = '0;
                    if (l.last) begin
                        next_l.wr_n = 1'b1;
                        next_l.st = L_UD_STOP;
                    end else begin
                        next_l.rd_n = 1'b0;
                        next_l.st = L_UD_RUN;
                    end
                end
            end
            L_UD_STOP: begin
                // leaving the burst restores the plain pin meanings
                if (l.cnt + ONE8 >= ihh_cyc(BURST_STOP_NS)) begin
                    next_l.dmack_n = 1'b1;
                    next_l.st = L_IDLE;
                end
            end
            default: begin
                next_l.st = L_IDLE;
            end
        endcase
    end

    always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
            l <= '0;
            l.rd_n <= 1'b1;
            l.wr_n <= 1'b1;
            l.dmack_n <= 1'b1;
            l.ce0_n <= 1'b1;
            l.ce1_n <= 1'b1;
            l.doe_n <= 1'b1;
        end else begin
            l <= next_l;
        end
    end

    assign cmd_ready = u.idle;
    assign rsp_valid = u.rsp_valid;
    assign rsp_data = u.rsp_data;
    assign rsp_wide = u.rsp_wide;
    assign rsp_last = u.rsp_last;
    assign irq = u.irq;
    assign host_read_strobe_n = l.rd_n;
    assign host_write_strobe_n = l.wr_n;
    assign register_space_select_n = l.dmack_n;
    assign card_enable_low_byte_n = l.ce0_n;
    assign card_enable_high_byte_n = l.ce1_n;
    assign host_address_low = l.addr;
    assign host_data_out = l.dout;
    assign host_data_oe_n = l.doe_n;

endmodule : ihh_host

`default_nettype wire

// ===== design/ihh_sync.sv
`timescale 1ns/10ps
`default_nettype none

// two-stage level synchroniser; stage one feeds stage two only
module ihh_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } ihh_sync_s;

    ihh_sync_s r;
    ihh_sync_s next_r;

    // no reset: a synchroniser only forwards what it sees
    always_comb begin
        next_r = r;
        next_r.s1 = d;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge clk) begin
        r <= next_r;
    end

    assign q = r.s2;

endmodule : ihh_sync

`default_nettype wire

// ===== design/ihh_unused_placeholder_removed.sv
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// ===== dv/ihh_dev_model.sv
`timescale 1ns/10ps
`default_nettype none

// device end: waits, read data, dma request and burst words
module ihh_dev_model (
    input wire logic link_clk,
    input wire logic host_read_strobe_n,
    input wire logic host_write_strobe_n,
    input wire logic register_space_select_n,
    input wire logic card_enable_high_byte_n,
    input wire logic card_enable_low_byte_n,
    input wire logic [2:0] host_address_low,
    input wire logic [15:0] host_data_out,
    input wire logic [7:0] wait_len,
    input wire logic [15:0] rdata,
    input wire logic dma_on,
    input wire logic udma,
    input wire logic irq_in,
    output logic [15:0] host_data_in,
    output logic io_ready,
    output wire logic dma_request,
    output wire logic wide_xfer_n,
    output wire logic interrupt_out,
    output logic [15:0] wr_word,
    output logic [3:0] wr_where,
    output logic [7:0] act_len,
    output logic [7:0] rec_len
);
    wire rd_n = host_read_strobe_n;
    wire ack_n = register_space_select_n;
    wire burst = udma && !ack_n;
    logic [7:0] cnt = 8'h00;
    logic [7:0] rec = 8'h00;
    logic [7:0] ucnt = 8'h00;
    logic rd_q = 1'b1;
    logic pend = 1'b0;

    // wide shown whenever selected; the host must filter it by mode
    assign dma_request = dma_on;
    assign wide_xfer_n = card_enable_low_byte_n && card_enable_high_byte_n;
    assign interrupt_out = irq_in;

    initial begin
        io_ready = 1'b1;
        host_data_in = 16'h0000;
    end

    // data before each strobe edge, one word per host ready
    always @(posedge link_clk) begin
        rd_q <= rd_n;
        if (burst) begin
            if (rd_q && !rd_n) begin
                host_data_in <= rdata + {8'h00, ucnt};
                ucnt <= ucnt + 8'h01;
                pend <= 1'b1;
            end else if (pend) begin
                io_ready <= !io_ready;
                pend <= 1'b0;
            end
        end else if (!rd_n || !host_write_strobe_n) begin
            cnt <= cnt + 8'h01;
            io_ready <= !(ack_n && cnt < wait_len);
            if (!rd_n && cnt >= wait_len) begin
                host_data_in <= rdata ^ {13'h0000, host_address_low & {3{ack_n}}};
            end else begin
                host_data_in <= ~host_data_in;
            end
            if (!host_write_strobe_n) begin
                wr_word <= host_data_out;
                wr_where <= {!card_enable_high_byte_n, host_address_low};
            end
        end else begin
            // a released bus never keeps its last value
            ucnt <= 8'h00;
            io_ready <= 1'b1;
            host_data_in <= ~host_data_in;
            rec <= (cnt != 8'h00) ? 8'h01 : rec + 8'h01;
            // recovery so far stands before the host's answer can arrive
            if (!ack_n) begin
                rec_len <= (cnt != 8'h00) ? 8'h01 : rec + 8'h01;
            end
            if (cnt != 8'h00) begin
                act_len <= cnt;
            end
            cnt <= 8'h00;
        end
    end
endmodule : ihh_dev_model

`default_nettype wire

// ===== dv/ihh_host_asserts.sv
`timescale 1ns/10ps
`default_nettype none

// pin and command relations, seen only from the host's ports
module ihh_host_asserts (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic link_clk,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire logic irq,
    input wire logic host_read_strobe_n,
    input wire logic host_write_strobe_n,
    input wire logic register_space_select_n,
    input wire logic card_enable_low_byte_n,
    input wire logic card_enable_high_byte_n,
    input wire logic host_data_oe_n,
    input wire logic dma_request,
    input wire logic interrupt_out
);
    // link side: outside dma only one strobe may be active
    one_strobe_a: assert property (@(posedge link_clk) disable iff (!resetn)
        register_space_select_n |-> host_read_strobe_n || host_write_strobe_n)
        else $error("both strobes low outside dma");
    pio_select_a: assert property (@(posedge link_clk) disable iff (!resetn)
        register_space_select_n && !(host_read_strobe_n && host_write_strobe_n)
        |-> !(card_enable_low_byte_n && card_enable_high_byte_n))
        else $error("pio strobe without a card enable");
    dma_no_cs_a: assert property (@(posedge link_clk) disable iff (!resetn)
        !register_space_select_n
        |-> card_enable_low_byte_n && card_enable_high_byte_n)
        else $error("card enable active during dma");
    write_drive_a: assert property (@(posedge link_clk) disable iff (!resetn)
        register_space_select_n && !host_write_strobe_n |-> !host_data_oe_n)
        else $error("write strobe without data driven");
    active_min_a: assert property (@(posedge link_clk) disable iff (!resetn)
        register_space_select_n && $fell(host_read_strobe_n)
        |=> !host_read_strobe_n) else $error("read strobe too short");
    dma_gate_a: assert property (@(posedge link_clk) disable iff (!resetn)
        !register_space_select_n && $fell(host_read_strobe_n)
        |-> $past(dma_request)) else $error("dma strobe without request");
    // user side
    cmd_take_a: assert property (@(posedge mclk) disable iff (!resetn)
        cmd_valid && cmd_ready |=> !cmd_ready)
        else $error("still ready after taking a command");
    irq_follow_a: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(interrupt_out) |-> ##[1:3] irq)
        else $error("interrupt not passed on");
endmodule : ihh_host_asserts

`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
    import ihh_pkg::*;
    logic mclk, link_clk, cmd_ready, rsp_valid, rsp_wide, rsp_last, irq;
    logic resetn = 1'b0, cmd_valid = 1'b0, cmd_byte = 1'b0, cmd_cs1 = 1'b0;
    logic dma_pause = 1'b0, dma_on = 1'b1, udma = 1'b0, irq_in = 1'b0;
    ihh_kind_e cmd_kind = IHH_PIO_RD;
    logic [2:0] cmd_mode = 3'h0, cmd_addr = 3'h0, host_address_low;
    logic [7:0] cmd_len = 8'h01, wait_len = 8'h00, act_len, rec_len;
    logic [15:0] cmd_wdata = 16'h0000, rdata = 16'h0000, rsp_data, got;
    logic [15:0] host_data_out, host_data_in, wr_word;
    logic host_read_strobe_n, host_write_strobe_n, register_space_select_n;
    logic card_enable_low_byte_n, card_enable_high_byte_n, host_data_oe_n;
    logic io_ready, dma_request, wide_xfer_n, interrupt_out;
    logic got_wide, got_last;
    logic [3:0] wr_where;
    int mismatches = 0, comparisons = 0, cycles = 0;

    ihh_host uut (.*);
    ihh_dev_model dev (.*);

    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // link clock free running, phase unrelated to mclk
    initial begin
        link_clk = 1'b0;
        #7;
        forever #16 link_clk = ~link_clk;
    end

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input string w, input logic [15:0] seen,
                         input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", w, exp, seen);
        end
    endtask : check

    function automatic int cyc(input int ns);
        return (ns + LINK_NS - 1) / LINK_NS;
    endfunction : cyc

    task automatic at_least(input string w, input logic [8:0] seen,
                            input int lim);
        check(w, 16'(seen >= 9'(lim)), 16'h0001);
    endtask : at_least

    task automatic send(input ihh_kind_e k, input logic [2:0] m,
                        input logic [2:0] a, input logic [15:0] d);
        @(posedge mclk);
        cmd_kind <= k;
        cmd_mode <= m;
        cmd_addr <= a;
        cmd_wdata <= d;
        cmd_valid <= 1'b1;
        do @(posedge mclk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
    endtask : send

    task automatic get;
        do @(posedge mclk); while (rsp_valid !== 1'b1);
        got = rsp_data;
        got_wide = rsp_wide;
        got_last = rsp_last;
    endtask : get

    // no answer may come while the transfer is held back
    task automatic idle_for(input string w);
        int n = 0;
        repeat (80) begin
            @(posedge mclk);
            n += (rsp_valid !== 1'b0);
        end
        check(w, 16'(n), 16'h0000);
    endtask : idle_for

    task automatic pio_modes;
        for (int m = 0; m < PIO_MODES; m++) begin
            rdata <= 16'h3c00 + 16'(m);
            cmd_cs1 <= m[0];
            send(IHH_PIO_RD, 3'(m), 3'(7 - m), 16'h0000);
            get;
            check("pio dat", got, (16'h3c00 + 16'(m)) ^ 16'(7 - m));
            check("pio wide", 16'(got_wide), 16'(m <= 2));
            check("pio last", 16'(got_last), 16'h0001);
            at_least("pio act", 9'(act_len), cyc(PIO_T2[m]));
        end
    endtask : pio_modes

    task automatic pio_wait;
        wait_len <= 8'h0c;
        rdata <= 16'ha5c3;
        send(IHH_PIO_RD, 3'h0, 3'h1, 16'h0000);
        get;
        check("wait dat", got, 16'ha5c2);
        at_least("wait held", 9'(act_len), 12 + SYNC_LAG);
        send(IHH_PIO_RD, 3'h6, 3'h1, 16'h0000);
        get;
        check("no wait", 16'(act_len < 8'h0c), 16'h0001);
        wait_len <= 8'h00;
    endtask : pio_wait

    task automatic pio_write;
        cmd_byte <= 1'b1;
        cmd_cs1 <= 1'b1;
        send(IHH_PIO_WR, 3'h2, 3'h5, 16'h5aa5);
        get;
        check("byte wr", wr_word, 16'h00a5);
        check("wr place", 16'(wr_where), 16'h000d);
        cmd_byte <= 1'b0;
    endtask : pio_write

    task automatic dma_mode0;
        rdata <= 16'h1234;
        send(IHH_DMA_RD, 3'h0, 3'h0, 16'h0000);
        get;
        check("dma rd", got, 16'h1234);
        at_least("rd act", 9'(act_len), cyc(DMA_ACTIVE_MIN[0]));
        at_least("rd rec", 9'(rec_len), cyc(DMA_READ_RECOVERY_MIN[0]));
        at_least("rd tot", 9'(act_len) + 9'(rec_len), cyc(DMA_T0[0]));
        send(IHH_DMA_WR, 3'h0, 3'h0, 16'hc0de);
        get;
        check("dma wr", wr_word, 16'hc0de);
        at_least("wr rec", 9'(rec_len), cyc(DMA_WRITE_RECOVERY_MIN[0]));
        at_least("wr tot", 9'(act_len) + 9'(rec_len), cyc(DMA_T0[0]));
    endtask : dma_mode0

    task automatic dma_hold;
        dma_on <= 1'b0;
        rdata <= 16'h0bad;
        send(IHH_DMA_RD, 3'h4, 3'h0, 16'h0000);
        idle_for("suspend");
        dma_on <= 1'b1;
        get;
        check("resume", got, 16'h0bad);
        dma_pause <= 1'b1;
        send(IHH_DMA_RD, 3'h4, 3'h0, 16'h0000);
        idle_for("paused");
        dma_pause <= 1'b0;
        get;
        check("unpause", got, 16'h0bad);
    endtask : dma_hold

    task automatic udma_burst;
        udma <= 1'b1;
        rdata <= 16'h7100;
        cmd_len <= 8'h03;
        send(IHH_UDMA_RD, 3'h2, 3'h0, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            get;
            check("burst dat", got, 16'h7100 + 16'(i));
            check("burst last", 16'(got_last), 16'(i == 2));
            check("burst wide", 16'(got_wide), 16'h0001);
        end
        udma <= 1'b0;
        rdata <= 16'h0f0f;
        send(IHH_PIO_RD, 3'h0, 3'h0, 16'h0000);
        get;
        check("after burst", got, 16'h0f0f);
    endtask : udma_burst

    task automatic irq_path;
        irq_in <= 1'b1;
        repeat (4) @(posedge mclk);
        check("irq set", 16'(irq), 16'h0001);
        irq_in <= 1'b0;
        repeat (4) @(posedge mclk);
        check("irq clr", 16'(irq), 16'h0000);
    endtask : irq_path

    // reset held long enough for the link side to see it too
    initial begin
        repeat (30) @(posedge mclk);
        resetn <= 1'b1;
        repeat (30) @(posedge mclk);
        pio_modes;
        pio_wait;
        pio_write;
        dma_mode0;
        dma_hold;
        udma_burst;
        irq_path;
        report_and_stop;
    end

    // hang guard: the whole run needs well under this many cycles
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            mismatches++;
            report_and_stop;
        end
    end
endmodule : tb

bind ihh_host ihh_host_asserts chk (.*);

`default_nettype wire

// ===== pkg/ihh_pkg.sv
package ihh_pkg;

    // user command kinds
    typedef enum logic [2:0] {
        IHH_PIO_RD,
        IHH_PIO_WR,
        IHH_DMA_RD,
        IHH_DMA_WR,
        IHH_UDMA_RD
    } ihh_kind_e;

    // link clock period, used to turn nanoseconds into link cycles
    localparam int LINK_NS = 32;
    // the pin synchronisers delay every sampled pin by this many cycles
    localparam int SYNC_LAG = 2;

    localparam int PIO_MODES = 7;
    localparam int DMA_MODES = 5;
    localparam logic [2:0] DMA_TOP_MODE = 3'h4;
    localparam logic [2:0] WAIT_TOP_MODE = 3'h4;   // io_ready honoured up to here
    localparam logic [2:0] WIDE_TOP_MODE = 3'h2;   // wide indication valid to here

    // programmed-io timing, ns, index is mode
    localparam int PIO_T0 [PIO_MODES] = '{600, 383, 240, 180, 120, 100, 80};
    localparam int PIO_T1 [PIO_MODES] = '{70, 50, 30, 30, 25, 15, 10};
    localparam int PIO_T2 [PIO_MODES] = '{165, 125, 100, 80, 70, 65, 55};
    localparam int PIO_T2B [PIO_MODES] = '{290, 290, 290, 80, 70, 65, 55};
    localparam int PIO_T2I [PIO_MODES] = '{0, 0, 0, 70, 25, 25, 20};
    localparam int WAIT_SAMPLE_DELAY_NS = 35;

    // multiword dma timing, ns, index is mode
    localparam int DMA_T0 [DMA_MODES] = '{480, 150, 120, 100, 80};
    localparam int DMA_ACTIVE_MIN [DMA_MODES] = '{215, 80, 70, 65, 65};
    localparam int DMA_READ_RECOVERY_MIN [DMA_MODES] = '{50, 50, 25, 25, 20};
    localparam int DMA_WRITE_RECOVERY_MIN [DMA_MODES] = '{215, 50, 25, 25, 20};
    localparam int DMA_CE_SETUP [DMA_MODES] = '{50, 30, 25, 10, 5};

    // burst end: hold stop before releasing the acknowledge
    localparam int BURST_STOP_NS = 50;

    localparam logic [7:0] ONE8 = 8'h01;
    localparam logic [15:0] BYTE_MASK = 16'h00ff;

    // nanoseconds to whole link cycles, rounded up, never below one
    function automatic logic [7:0] ihh_cyc(input int ns);
        int c;
        c = (ns + LINK_NS - 1) / LINK_NS;
        if (c < 1) begin
            c = 1;
        end
        return c[7:0];
    endfunction : ihh_cyc

endpackage : ihh_pkg
